/* optical_mux_pkg.sv */
// Shared constants and types for the optical port timeslot multiplexer
//==============================================================================
// Summary of operation
// - A standby port claims no trunk slots; only active ports send slot data.
// - Each port feeds exactly one trunk: none, four electrical or four optical.
// - One to twelve slots of one trunk form a port's super-rate channel.
// - Slot numbers 1 to 24 are valid on T1, 1 to 31 on E1.
// - A slot map with gaps between assigned slots is refused.
// - Port payload is N times 64 kbps, one byte per slot per frame.
// - The port always runs as a multiplexer; no other mode exists.
// - Optical transmit timing comes from the internal frame clock, except user loopback echoes, which follow equipment data.
// - User loopback returns equipment data straight back to the equipment.
// - User loopback stops trunk data reaching the local equipment.
// - Network loopback returns trunk data to the far end; default off.
// - Link status reads normal when neither direction has a fault.
// - Link status reads yellow when the equipment reports a reception fault and no optical receive fault is detected.
// - Link status reads red when the port detects an optical receive fault.
// - Transmit and receive directions run separately and at the same time.
package optical_mux_pkg;
  //============================================================================
  // Widths
  localparam int PORTS = 32'h0000_0002;
  localparam int BYTE_W = 32'h0000_0008;
  localparam int SLOT_W = 32'h0000_0005;
  localparam int DEST_W = 32'h0000_0004;
  localparam int MAP_W = 32'h0000_0020;
  localparam int OFS_W = 32'h0000_0004;
  localparam int ADDR_W = 32'h0000_0005;
  //============================================================================
  // Destination codes: 1..4 electrical trunks, 5..8 optical trunks
  localparam logic [3:0] DEST_NONE = 4'h0;
  localparam logic [3:0] DEST_LAST = 4'h8;
  //============================================================================
  // Slot map limits
  localparam logic [5:0] MAX_SLOTS = 6'h0c;
  localparam logic [4:0] T1_LAST_SLOT = 5'h18;
  localparam logic [4:0] E1_LAST_SLOT = 5'h1f;
  //============================================================================
  // Loopback settings
  localparam logic [1:0] LOOP_OFF = 2'h0;
  localparam logic [1:0] LOOP_USER = 2'h1;
  localparam logic [1:0] LOOP_NET = 2'h2;
  //============================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 32'h0000_0028;
  localparam int FRAME_NS = 32'h0001_e848;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;
  localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYCLES - 1);
  localparam logic [4:0] SEQ_LAST = 5'h17;
  //============================================================================
  // Reset values
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  //============================================================================
  // States
  typedef enum logic [2:0] {
    ALARM_NORM = 3'h1,
    ALARM_YELLOW = 3'h2,
    ALARM_RED = 3'h4
  } alarm_type;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h1,
    SEQ_SEND = 2'h2
  } seq_type;
endpackage

/* slot_map_check.sv */
// Validation of one port's trunk slot map
module slot_map_check (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [optical_mux_pkg::MAP_W-1:0] trunk_slot_map,
  input wire logic trunk_is_e1,
  output logic map_valid,
  output logic [optical_mux_pkg::SLOT_W-1:0] first_slot,
  output logic [optical_mux_pkg::OFS_W-1:0] slot_count
);
  typedef struct packed {
    logic valid;
    logic [4:0] first;
    logic [3:0] count;
  } check_state_type;

  check_state_type st_reg, st_next;

  always_comb begin
    logic [4:0] lo;
    logic [4:0] hi;
    logic [5:0] cnt;
    logic [4:0] limit;
    logic contig;
    lo = 5'h00;
    hi = 5'h00;
    cnt = 6'h00;
    limit = trunk_is_e1 ? optical_mux_pkg::E1_LAST_SLOT : optical_mux_pkg::T1_LAST_SLOT;
    for (int i = optical_mux_pkg::MAP_W - 1; i >= 0; i--) begin
      if (trunk_slot_map[i]) begin
        lo = 5'(i);
      end
    end
    for (int i = 0; i < optical_mux_pkg::MAP_W; i++) begin
      if (trunk_slot_map[i]) begin
        hi = 5'(i);
        cnt = cnt + 6'h01;
      end
    end
    // Span equals population only when there are no gaps
    contig = (6'(hi) - 6'(lo) + 6'h01) == cnt;
    st_next.valid = contig && (cnt != 6'h00) && (cnt <= optical_mux_pkg::MAX_SLOTS)
      && !trunk_slot_map[0] && (hi <= limit);
    st_next.first = lo;
    st_next.count = 4'(cnt);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign map_valid = st_reg.valid;
  assign first_slot = st_reg.first;
  assign slot_count = st_reg.count;
endmodule // slot_map_check

/* frame_store.sv */
// Small byte store holding one trunk frame of slot data for both ports
module frame_store (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [optical_mux_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [optical_mux_pkg::BYTE_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [optical_mux_pkg::ADDR_W-1:0] rd_addr,
  output logic [optical_mux_pkg::BYTE_W-1:0] rd_data
);
  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [7:0] rd_data;
  } store_state_type;

  store_state_type st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      st_next.rd_data = st_reg.mem[rd_addr];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
endmodule // frame_store

/* optical_port_timeslot_mux.sv */
// Two optical data ports multiplexed into contiguous trunk timeslots
module optical_port_timeslot_mux (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [optical_mux_pkg::PORTS-1:0] port_active,
  input wire logic [optical_mux_pkg::PORTS-1:0][optical_mux_pkg::DEST_W-1:0] destination_select,
  input wire logic [optical_mux_pkg::PORTS-1:0] trunk_is_e1,
  input wire logic [optical_mux_pkg::PORTS-1:0][optical_mux_pkg::MAP_W-1:0] trunk_slot_map,
  input wire logic [optical_mux_pkg::PORTS-1:0][1:0] local_loop_setting,
  input wire logic slot_strobe,
  input wire logic [optical_mux_pkg::DEST_W-1:0] slot_trunk,
  input wire logic [optical_mux_pkg::SLOT_W-1:0] slot_number,
  input wire logic [optical_mux_pkg::BYTE_W-1:0] slot_rx_byte,
  output logic slot_tx_valid,
  output logic [optical_mux_pkg::BYTE_W-1:0] slot_tx_byte,
  input wire logic [optical_mux_pkg::PORTS-1:0] opt_rx_valid,
  input wire logic [optical_mux_pkg::PORTS-1:0][optical_mux_pkg::BYTE_W-1:0] opt_rx_byte,
  input wire logic [optical_mux_pkg::PORTS-1:0] opt_rx_fault,
  input wire logic [optical_mux_pkg::PORTS-1:0] opt_rx_remote_fault,
  output logic [optical_mux_pkg::PORTS-1:0] opt_tx_valid,
  output logic [optical_mux_pkg::PORTS-1:0][optical_mux_pkg::BYTE_W-1:0] opt_tx_byte,
  output logic [optical_mux_pkg::PORTS-1:0] opt_tx_remote_defect,
  output logic [optical_mux_pkg::PORTS-1:0][2:0] link_alarm,
  output logic [optical_mux_pkg::PORTS-1:0] map_rejected,
  output logic [optical_mux_pkg::PORTS-1:0] port_online,
  output logic mux_mode
);
  typedef struct packed {
    logic [11:0] frame_cnt;
    optical_mux_pkg::seq_type seq;
    logic [4:0] seq_idx;
    logic rd_pend;
    logic rd_port;
    logic [1:0] online;
    logic [1:0][7:0] hold_byte;
    logic slot_valid;
    logic slot_net;
    logic [7:0] slot_byte;
    logic [1:0] tx_valid;
    logic [1:0][7:0] tx_byte;
    logic [1:0] rdi;
    logic [1:0][2:0] alarm;
  } main_state_type;

  main_state_type st_reg, st_next;

  logic [optical_mux_pkg::PORTS-1:0] map_valid;
  logic [optical_mux_pkg::PORTS-1:0][optical_mux_pkg::SLOT_W-1:0] first_slot;
  logic [optical_mux_pkg::PORTS-1:0][optical_mux_pkg::OFS_W-1:0] slot_count;
  logic mem_wr_en;
  logic [optical_mux_pkg::ADDR_W-1:0] mem_wr_addr;
  logic mem_rd_en;
  logic [optical_mux_pkg::ADDR_W-1:0] mem_rd_addr;
  logic [optical_mux_pkg::BYTE_W-1:0] mem_rd_data;

  //============================================================================
  // Slot map checking and frame storage
  for (genvar p = 0; p < optical_mux_pkg::PORTS; p++) begin : g_check
    slot_map_check u_check (
      .clk_sys(clk_sys),
      .reset(reset),
      .trunk_slot_map(trunk_slot_map[p]),
      .trunk_is_e1(trunk_is_e1[p]),
      .map_valid(map_valid[p]),
      .first_slot(first_slot[p]),
      .slot_count(slot_count[p])
    );
  end

  frame_store u_store (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(slot_rx_byte),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  //============================================================================
  // Slot ownership test
  function automatic logic slot_hit(input logic online, input logic [3:0] dest,
      input logic [4:0] first, input logic [3:0] count);
    logic [5:0] end_slot;
    end_slot = {1'b0, first} + {2'b00, count};
    slot_hit = online && (slot_trunk == dest) && (slot_number >= first)
      && ({1'b0, slot_number} < end_slot);
  endfunction

  //============================================================================
  // Next state
  always_comb begin
    logic hit;
    logic hit_port;
    logic [3:0] ofs;
    logic rd_p;
    logic [3:0] rd_ofs;
    hit = 1'b0;
    hit_port = 1'b0;
    ofs = 4'h0;
    rd_p = 1'b0;
    rd_ofs = 4'h0;
    st_next = st_reg;
    mem_wr_en = 1'b0;
    mem_rd_en = 1'b0;
    mem_rd_addr = 5'h00;
    for (int p = 0; p < optical_mux_pkg::PORTS; p++) begin
      st_next.online[p] = port_active[p] && map_valid[p]
        && (destination_select[p] != optical_mux_pkg::DEST_NONE)
        && (destination_select[p] <= optical_mux_pkg::DEST_LAST);
    end
    // Lower port number wins a shared slot
    for (int p = optical_mux_pkg::PORTS - 1; p >= 0; p--) begin
      if (slot_strobe && slot_hit(st_reg.online[p], destination_select[p], first_slot[p],
          slot_count[p])) begin
        hit = 1'b1;
        hit_port = 1'(p);
        ofs = 4'(slot_number - first_slot[p]);
      end
    end
    st_next.slot_valid = hit;
    st_next.slot_net = hit && (local_loop_setting[hit_port] == optical_mux_pkg::LOOP_NET);
    if (hit) begin
      st_next.slot_byte = st_next.slot_net ? slot_rx_byte : st_reg.hold_byte[hit_port];
    end
    mem_wr_en = hit && (local_loop_setting[hit_port] != optical_mux_pkg::LOOP_USER);
    mem_wr_addr = {hit_port, ofs};
    // Receive direction keeps running beside transmit
    for (int p = 0; p < optical_mux_pkg::PORTS; p++) begin
      if (opt_rx_valid[p]) begin
        st_next.hold_byte[p] = opt_rx_byte[p];
      end
    end
    // Internal frame timer paces every optical transmit except user loopback echoes
    if (st_reg.frame_cnt == optical_mux_pkg::FRAME_LAST) begin
      st_next.frame_cnt = 12'h000;
    end else begin
      st_next.frame_cnt = st_reg.frame_cnt + 12'h001;
    end
    unique case (st_reg.seq)
      optical_mux_pkg::SEQ_IDLE: begin
        if (st_reg.frame_cnt == optical_mux_pkg::FRAME_LAST) begin
          st_next.seq = optical_mux_pkg::SEQ_SEND;
          st_next.seq_idx = 5'h00;
        end
      end
      optical_mux_pkg::SEQ_SEND: begin
        rd_p = st_reg.seq_idx[0];
        rd_ofs = st_reg.seq_idx[4:1];
        // N bytes per frame per port
        mem_rd_en = st_reg.online[rd_p] && (rd_ofs < slot_count[rd_p])
          && (local_loop_setting[rd_p] != optical_mux_pkg::LOOP_USER);
        mem_rd_addr = {rd_p, rd_ofs};
        if (st_reg.seq_idx == optical_mux_pkg::SEQ_LAST) begin
          st_next.seq = optical_mux_pkg::SEQ_IDLE;
        end else begin
          st_next.seq_idx = st_reg.seq_idx + 5'h01;
        end
      end
      default: begin
        st_next.seq = optical_mux_pkg::SEQ_IDLE;
      end
    endcase
    st_next.rd_pend = mem_rd_en;
    st_next.rd_port = rd_p;
    for (int p = 0; p < optical_mux_pkg::PORTS; p++) begin
      st_next.tx_valid[p] = 1'b0;
      if ((local_loop_setting[p] == optical_mux_pkg::LOOP_USER) && opt_rx_valid[p]) begin
        st_next.tx_valid[p] = 1'b1;
        st_next.tx_byte[p] = opt_rx_byte[p];
      end else if (st_reg.rd_pend && (st_reg.rd_port == 1'(p))) begin
        st_next.tx_valid[p] = 1'b1;
        st_next.tx_byte[p] = mem_rd_data;
      end
      // Red outranks yellow
      if (opt_rx_fault[p]) begin
        st_next.alarm[p] = optical_mux_pkg::ALARM_RED;
      end else if (opt_rx_remote_fault[p]) begin
        st_next.alarm[p] = optical_mux_pkg::ALARM_YELLOW;
      end else begin
        st_next.alarm[p] = optical_mux_pkg::ALARM_NORM;
      end
      st_next.rdi[p] = opt_rx_fault[p];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.seq <= optical_mux_pkg::SEQ_IDLE;
      st_reg.slot_byte <= optical_mux_pkg::BYTE_RESET;
      st_reg.alarm <= {optical_mux_pkg::ALARM_NORM, optical_mux_pkg::ALARM_NORM};
    end else begin
      st_reg <= st_next;
    end
  end

  //============================================================================
  // Outputs
  assign slot_tx_valid = st_reg.slot_valid;
  assign slot_tx_byte = st_reg.slot_byte;
  assign opt_tx_valid = st_reg.tx_valid;
  assign opt_tx_byte = st_reg.tx_byte;
  assign opt_tx_remote_defect = st_reg.rdi;
  assign link_alarm = st_reg.alarm;
  assign port_online = st_reg.online;
  assign map_rejected = ~map_valid & port_active;
  assign mux_mode = 1'b1;

  //============================================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  standby_no_claim_a: assert property (
    slot_strobe && (st_reg.online == 2'b00) |=> !slot_tx_valid)
    else $error("slot claimed while no port online");

  dest_chosen_a: assert property (
    slot_tx_valid |-> ($past(slot_trunk) != optical_mux_pkg::DEST_NONE)
      && ($past(slot_trunk) <= optical_mux_pkg::DEST_LAST))
    else $error("slot claimed on an invalid trunk");

  slot_count_a: assert property (
    map_valid[0] |-> (slot_count[0] != 4'h0) && (slot_count[0] <= 4'hc))
    else $error("accepted slot count out of range");

  slot_number_a: assert property (
    slot_tx_valid |-> ($past(slot_number) != 5'h00))
    else $error("slot zero was claimed");

  map_gap_a: assert property (
    $rose(map_valid[0]) |-> $past(trunk_slot_map[0])
      == (((32'h0000_0001 << slot_count[0]) - 32'h0000_0001) << first_slot[0]))
    else $error("non-contiguous map accepted");

  frame_burst_a: assert property (
    $rose(st_reg.seq == optical_mux_pkg::SEQ_SEND)
      |-> ##24 (st_reg.seq == optical_mux_pkg::SEQ_IDLE))
    else $error("frame read burst not 24 cycles");

  internal_timing_a: assert property (
    $rose(st_reg.seq == optical_mux_pkg::SEQ_SEND)
      |-> $past(st_reg.frame_cnt) == optical_mux_pkg::FRAME_LAST)
    else $error("transmit burst not on the frame timer");

  user_loop_echo_a: assert property (
    opt_rx_valid[0] && (local_loop_setting[0] == optical_mux_pkg::LOOP_USER)
      |=> opt_tx_valid[0] && (opt_tx_byte[0] == $past(opt_rx_byte[0])))
    else $error("user loopback did not echo");

  user_loop_block_a: assert property (
    st_reg.rd_pend && !st_reg.rd_port
      |-> $past(local_loop_setting[0]) != optical_mux_pkg::LOOP_USER)
    else $error("trunk data read during user loopback");

  net_loop_a: assert property (
    slot_tx_valid && st_reg.slot_net |-> slot_tx_byte == $past(slot_rx_byte))
    else $error("network loopback byte mismatch");

  alarm_norm_a: assert property (
    !opt_rx_fault[0] && !opt_rx_remote_fault[0] |=> link_alarm[0] == optical_mux_pkg::ALARM_NORM)
    else $error("alarm not normal");

  alarm_yellow_a: assert property (
    !opt_rx_fault[0] && opt_rx_remote_fault[0] |=> link_alarm[0] == optical_mux_pkg::ALARM_YELLOW)
    else $error("alarm not yellow");

  alarm_red_a: assert property (
    opt_rx_fault[0] |=> (link_alarm[0] == optical_mux_pkg::ALARM_RED) && opt_tx_remote_defect[0])
    else $error("alarm not red with defect flag");

  defect_flag_a: assert property (
    opt_tx_remote_defect[1] |-> link_alarm[1] == optical_mux_pkg::ALARM_RED)
    else $error("defect flag without red alarm");

  standby_offline_a: assert property (
    !port_active[1] |=> !port_online[1])
    else $error("standby port went online");

  user_echo_one_a: assert property (
    opt_rx_valid[1] && (local_loop_setting[1] == optical_mux_pkg::LOOP_USER)
      |=> opt_tx_valid[1] && (opt_tx_byte[1] == $past(opt_rx_byte[1])))
    else $error("user loopback did not echo on port one");

  user_block_one_a: assert property (
    st_reg.rd_pend && st_reg.rd_port
      |-> $past(local_loop_setting[1]) != optical_mux_pkg::LOOP_USER)
    else $error("trunk data read for port one during user loopback");

  red_alarm_one_a: assert property (
    opt_rx_fault[1] |=> link_alarm[1] == optical_mux_pkg::ALARM_RED)
    else $error("port one alarm not red");

  norm_alarm_one_a: assert property (
    !opt_rx_fault[1] && !opt_rx_remote_fault[1]
      |=> link_alarm[1] == optical_mux_pkg::ALARM_NORM)
    else $error("port one alarm not normal");

  net_loop_c: cover property (slot_tx_valid && st_reg.slot_net);
  trunk_to_optical_c: cover property (st_reg.rd_pend ##1 opt_tx_valid[st_reg.rd_port]);
  user_loop_c: cover property (opt_tx_valid[1] && (local_loop_setting[1] == optical_mux_pkg::LOOP_USER));
  red_alarm_c: cover property (link_alarm[0] == optical_mux_pkg::ALARM_RED);
endmodule // optical_port_timeslot_mux

/* protection_equipment_model.sv */
// Behavioural protection equipment attached to one optical data port
module protection_equipment_model (
  input wire logic clk_sys,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic report_fault,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  //============================================================================
  // Transmit side
  initial begin
    tx_valid = 1'b0;
    tx_byte = 8'h00;
    report_fault = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(negedge clk_sys);
    tx_valid = 1'b1;
    tx_byte = b;
    @(negedge clk_sys);
    tx_valid = 1'b0;
    tx_byte = ~b;
  endtask
  task automatic set_fault(input logic f);
    @(negedge clk_sys);
    report_fault = f;
  endtask
  //============================================================================
  // Receive side, independent of transmit
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      got.push_back(rx_byte);
    end
  end
endmodule // protection_equipment_model

/* tb.sv */
// Self-checking testbench of the optical port timeslot multiplexer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, slot_strobe, slot_tx_valid, mux_mode;
  logic [1:0] port_active, trunk_is_e1, opt_rx_fault;
  logic [1:0][3:0] destination_select;
  logic [1:0][31:0] trunk_slot_map;
  logic [1:0][1:0] local_loop_setting;
  logic [3:0] slot_trunk;
  logic [4:0] slot_number;
  logic [7:0] slot_rx_byte, slot_tx_byte;
  wire logic [1:0] eq_valid, eq_rf;
  wire logic [1:0][7:0] eq_byte;
  logic [1:0] opt_tx_valid, opt_tx_remote_defect, map_rejected, port_online;
  logic [1:0][7:0] opt_tx_byte;
  logic [1:0][2:0] link_alarm;
  int err_total, total_checks;
  //============================================================================
  // Instances
  optical_port_timeslot_mux dut (.clk_sys(clk_sys), .reset(reset),
    .port_active(port_active), .destination_select(destination_select),
    .trunk_is_e1(trunk_is_e1), .trunk_slot_map(trunk_slot_map),
    .local_loop_setting(local_loop_setting), .slot_strobe(slot_strobe),
    .slot_trunk(slot_trunk), .slot_number(slot_number), .slot_rx_byte(slot_rx_byte),
    .slot_tx_valid(slot_tx_valid), .slot_tx_byte(slot_tx_byte), .opt_rx_valid(eq_valid),
    .opt_rx_byte(eq_byte), .opt_rx_fault(opt_rx_fault), .opt_rx_remote_fault(eq_rf),
    .opt_tx_valid(opt_tx_valid), .opt_tx_byte(opt_tx_byte),
    .opt_tx_remote_defect(opt_tx_remote_defect), .link_alarm(link_alarm),
    .map_rejected(map_rejected), .port_online(port_online), .mux_mode(mux_mode));
  protection_equipment_model eq0 (.clk_sys(clk_sys), .tx_valid(eq_valid[0]),
    .tx_byte(eq_byte[0]), .report_fault(eq_rf[0]), .rx_valid(opt_tx_valid[0]),
    .rx_byte(opt_tx_byte[0]));
  protection_equipment_model eq1 (.clk_sys(clk_sys), .tx_valid(eq_valid[1]),
    .tx_byte(eq_byte[1]), .report_fault(eq_rf[1]), .rx_valid(opt_tx_valid[1]),
    .rx_byte(opt_tx_byte[1]));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  //============================================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cfg(input int p, input logic act, input logic [3:0] d, input logic e1,
                     input logic [31:0] m, input logic [1:0] lp);
    @(negedge clk_sys);
    port_active[p] = act;
    destination_select[p] = d;
    trunk_is_e1[p] = e1;
    trunk_slot_map[p] = m;
    local_loop_setting[p] = lp;
    repeat (3) @(negedge clk_sys);
  endtask
  // One trunk slot; claim looked at in the cycle after the strobe
  task automatic slot(input logic [3:0] t, input logic [4:0] n, input logic [7:0] b,
                      input logic v, input logic [7:0] eb);
    @(negedge clk_sys);
    slot_strobe = 1'b1;
    slot_trunk = t;
    slot_number = n;
    slot_rx_byte = b;
    @(negedge clk_sys);
    check(slot_tx_valid, v);
    if (v) begin
      check(slot_tx_byte, eb);
    end
    slot_strobe = 1'b0;
    slot_rx_byte = ~b;
  endtask
  task automatic map_case(input logic e1, input logic [31:0] m, input logic rej,
                          input logic [4:0] n);
    cfg(0, 1'b1, 4'h1, e1, m, 2'h0);
    check(map_rejected[0], rej);
    check(port_online[0], !rej);
    slot(4'h1, n, 8'h00, !rej, 8'ha5);
  endtask
  // Skip past one burst, then collect exactly one frame period
  task automatic frame(input int n, input logic [23:0] e);
    int k;
    k = 0;
    while (opt_tx_valid[0] !== 1'b1 && k < 3300) begin
      @(negedge clk_sys);
      k++;
    end
    repeat (40) @(negedge clk_sys);
    eq0.got.delete();
    repeat (3125) @(negedge clk_sys);
    check(eq0.got.size(), n);
    for (int i = 0; i < n; i++) begin
      check(eq0.got[i], e[8*i+:8]);
    end
  endtask
  task automatic alarm(input logic f, input logic rf, input logic [2:0] ea, input logic ed);
    eq0.set_fault(rf);
    opt_rx_fault = {f, f};
    @(negedge clk_sys);
    check(link_alarm[0], ea);
    check(opt_tx_remote_defect[0], ed);
    check(link_alarm[1], f ? 3'h4 : 3'h1);
    check(opt_tx_remote_defect[1], f);
  endtask
  //============================================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
  //============================================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    port_active = 2'h0;
    destination_select = '0;
    trunk_is_e1 = 2'h0;
    trunk_slot_map = '0;
    local_loop_setting = '0;
    opt_rx_fault = 2'h0;
    slot_strobe = 1'b0;
    slot_trunk = 4'h0;
    slot_number = 5'h00;
    slot_rx_byte = 8'h00;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    check(slot_tx_valid, 1'b0);
    check(link_alarm, 6'h09);
    check(port_online, 2'h0);
    check(mux_mode, 1'b1);
    cfg(0, 1'b0, 4'h1, 1'b0, 32'h0000_0038, 2'h0);
    check(port_online[0], 1'b0);
    slot(4'h1, 5'h03, 8'h00, 1'b0, 8'h00);
    eq0.send(8'ha5);
    for (int d = 1; d <= 8; d++) begin
      cfg(0, 1'b1, 4'(d), 1'b0, 32'h0000_0038, 2'h0);
      slot(4'(d), 5'h04, 8'h00, 1'b1, 8'ha5);
      slot(4'(d % 8 + 1), 5'h04, 8'h00, 1'b0, 8'h00);
    end
    cfg(0, 1'b1, 4'h0, 1'b0, 32'h0000_0038, 2'h0);
    check(port_online[0], 1'b0);
    cfg(0, 1'b1, 4'h9, 1'b0, 32'h0000_0038, 2'h0);
    check(port_online[0], 1'b0);
    map_case(1'b0, 32'h0000_0028, 1'b1, 5'h03);
    map_case(1'b0, 32'h0000_3ffe, 1'b1, 5'h01);
    map_case(1'b0, 32'h0000_1ffe, 1'b0, 5'h0c);
    map_case(1'b0, 32'h8000_0000, 1'b1, 5'h1f);
    map_case(1'b1, 32'h8000_0000, 1'b0, 5'h1f);
    map_case(1'b0, 32'h0100_0000, 1'b0, 5'h18);
    cfg(0, 1'b1, 4'h1, 1'b0, 32'h0000_0038, 2'h0);
    slot(4'h1, 5'h05, 8'h00, 1'b1, 8'ha5);
    slot(4'h1, 5'h06, 8'h00, 1'b0, 8'h00);
    slot(4'h1, 5'h02, 8'h00, 1'b0, 8'h00);
    cfg(0, 1'b1, 4'h1, 1'b0, 32'h0000_0038, 2'h2);
    slot(4'h1, 5'h03, 8'h77, 1'b1, 8'h77);
    cfg(0, 1'b1, 4'h1, 1'b0, 32'h0000_0038, 2'h0);
    slot(4'h1, 5'h03, 8'h11, 1'b1, 8'ha5);
    slot(4'h1, 5'h04, 8'h22, 1'b1, 8'ha5);
    slot(4'h1, 5'h05, 8'h33, 1'b1, 8'ha5);
    frame(3, 24'h33_2211);
    cfg(0, 1'b1, 4'h1, 1'b0, 32'h0000_0038, 2'h1);
    eq0.got.delete();
    eq0.send(8'h5a);
    repeat (2) @(negedge clk_sys);
    check(eq0.got.size(), 1);
    check(eq0.got[0], 8'h5a);
    frame(0, 24'h00_0000);
    cfg(1, 1'b1, 4'h8, 1'b0, 32'h0000_00c0, 2'h0);
    eq1.send(8'h3c);
    slot(4'h8, 5'h06, 8'h00, 1'b1, 8'h3c);
    cfg(1, 1'b1, 4'h8, 1'b0, 32'h0000_00c0, 2'h1);
    eq1.got.delete();
    eq1.send(8'h96);
    repeat (2) @(negedge clk_sys);
    check(eq1.got.size(), 1);
    check(eq1.got[0], 8'h96);
    alarm(1'b0, 1'b1, 3'h2, 1'b0);
    alarm(1'b1, 1'b1, 3'h4, 1'b1);
    alarm(1'b0, 1'b0, 3'h1, 1'b0);
    report_and_stop();
  end
endmodule // tb
